// *** sbc_status_pkg.sv ***
// constants, codes and carriers for the status readback and period decode block
// assumes one 16-bit serial frame per access and a 512 kHz period oscillator
package sbc_status_pkg;

  // ==================================================================
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int SEL_MSB = 15;
  localparam int SEL_LSB = 14;
  localparam int READBACK_BIT = 13;
  localparam int READ_ONLY_BIT = 12;
  localparam int CAUSE_MSB = 11;
  localparam int CAUSE_LSB = 8;
  localparam int CAN_WAKE_BIT = 7;
  localparam int PERIOD_MSB = 11;
  localparam int PERIOD_LSB = 6;
  localparam logic [1:0] SEL_STATUS = 2'h0;
  localparam logic READBACK_STATUS = 1'h0;
  localparam logic [4:0] BIT_COUNT_LAST = 5'h0f;

  // ==================================================================
  // reset values
  localparam logic [15:0] MODE_WORD_RESET = 16'h0000;
  localparam logic [3:0] CAUSE_RESET = 4'h0;
  localparam logic CAN_WAKE_RESET = 1'h0;

  // ==================================================================
  // reset cause codes
  localparam logic [3:0] CAUSE_POWER_ON = 4'h0;
  localparam logic [3:0] CAUSE_CYCLIC_WAKE = 4'h1;
  localparam logic [3:0] CAUSE_MAIN_LOW = 4'h2;
  localparam logic [3:0] CAUSE_MAIN_OVERCURRENT = 4'h3;
  localparam logic [3:0] CAUSE_AUX_OVERLOAD = 4'h4;
  localparam logic [3:0] CAUSE_FLASH_LEFT = 4'h5;
  localparam logic [3:0] CAUSE_FLASH_READY = 4'h6;
  localparam logic [3:0] CAUSE_CAN_WAKE = 4'h7;
  localparam logic [3:0] CAUSE_RESERVED = 4'h8;
  localparam logic [3:0] CAUSE_LOCAL_WAKE = 4'h9;
  localparam logic [3:0] CAUSE_FAILSAFE_WAKE = 4'ha;
  localparam logic [3:0] CAUSE_WD_OVERFLOW = 4'hb;
  localparam logic [3:0] CAUSE_WD_INIT_MISSED = 4'hc;
  localparam logic [3:0] CAUSE_WD_EARLY = 4'hd;
  localparam logic [3:0] CAUSE_ILLEGAL_ACCESS = 4'he;
  localparam logic [3:0] CAUSE_INT_NOT_SERVED = 4'hf;

  // ==================================================================
  // period table for prescale setting 11, milliseconds, 0 = watchdog off
  localparam logic [1:0] PRESCALE_TABLE = 2'h3;
  localparam int PERIOD_ENTRIES = 10;
  localparam logic [5:0] PERIOD_OFF_CODE = 6'h36;
  localparam logic [5:0] PERIOD_CODE [PERIOD_ENTRIES] =
    '{6'h09, 6'h0c, 6'h12, 6'h14, 6'h1b, 6'h24, 6'h2d, 6'h33, 6'h35, 6'h36};
  localparam logic [15:0] PERIOD_NORMAL_MS [PERIOD_ENTRIES] =
    '{16'h000e, 16'h001c, 16'h0038, 16'h0070, 16'h008c, 16'h00a8, 16'h00c4, 16'h00e0,
      16'h00fc, 16'h0118};
  localparam logic [15:0] PERIOD_STANDBY_MS [PERIOD_ENTRIES] =
    '{16'h0046, 16'h008c, 16'h0118, 16'h0230, 16'h0460, 16'h08c0, 16'h0e00, 16'h1c00,
      16'h3800, 16'h0000};
  localparam logic [15:0] PERIOD_FLASH_MS [PERIOD_ENTRIES] =
    '{16'h0046, 16'h008c, 16'h0118, 16'h0230, 16'h0460, 16'h08c0, 16'h0e00, 16'h1c00,
      16'h3800, 16'h7000};
  localparam logic [15:0] PERIOD_SLEEP_MS [PERIOD_ENTRIES] =
    '{16'h0230, 16'h0460, 16'h08c0, 16'h0e00, 16'h1c00, 16'h2a00, 16'h3800, 16'h5400,
      16'h7000, 16'h0000};

  // ==================================================================
  // oscillator: ticks per millisecond at 512 kHz
  localparam int OSC_KHZ = 512;
  localparam logic [23:0] OSC_TICKS_PER_MS = 24'(OSC_KHZ);

  // ==================================================================
  // types
  typedef enum logic [1:0] {MODE_NORMAL, MODE_STANDBY, MODE_FLASH, MODE_SLEEP} op_mode_t;

  typedef enum logic [1:0] {SLEEP_RUN, SLEEP_RESET_LOW, SLEEP_RAIL_OFF} sleep_state_t;

  // one pulse per reset source, all on the system clock
  typedef struct packed {
    logic power_on;
    logic cyclic_wake;
    logic main_low;
    logic main_overcurrent;
    logic aux_overload;
    logic flash_left;
    logic flash_ready;
    logic can_wake;
    logic local_wake;
    logic failsafe_wake;
    logic wd_overflow;
    logic wd_init_missed;
    logic wd_early;
    logic illegal_access;
    logic int_not_served;
  } cause_events_t;

  typedef struct packed {
    logic [1:0] register_select_bits;
    logic readback_select;
    logic read_without_write;
    logic [3:0] reset_cause;
    logic can_wake_flag;
    logic [6:0] low_bits;
  } status_word_t;

endpackage

// *** sbc_status_and_watchdog_period.sv ***
// status readback, mode control word, period decode and sleep entry sequencing
// assumes: frame pins async to clock; link_clock toggles only while link_select_n is low;
// host changes data on rising link_clock and samples on falling; events come on clock
//
// What this block does
// RL1 - prescale 11 maps ten six-bit period codes to per-mode nominal periods
// RL2 - code 110110 means watchdog off in standby and sleep, long period elsewhere
// RL3 - periods counted in internal oscillator ticks at 512 kHz
// RL4 - status word readable in every operating mode, never blocked
// RL5 - host selects status with select bits 00 and readback select 0
// RL6 - bit 12 set returns status only; clear also loads the mode control word
// RL7 - cause codes for supply events: power-on, main low, overcurrent, aux overload
// RL8 - cause codes for mode and wake events, code 1000 reserved
// RL9 - cause codes for watchdog, illegal access and unserved interrupt faults
// RL10 - can wake flag set on wake, cleared by a status read
// RL11 - sleep entry with watchdog off pulls reset low and stops the watchdog
// RL12 - main rail switched off only after reset output already low
// RL13 - reset cause overwritten by each new event, never cleared by reading
// RL14 - one 16-bit frame per access, msb first, status returned same frame
`timescale 1ns/1ps
`default_nettype none
module sbc_status_and_watchdog_period
  import sbc_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic link_clock,
  input wire logic link_select_n,
  input wire logic link_data_in,
  output logic link_data_out,
  input wire op_mode_t op_mode,
  input wire logic [1:0] period_prescale,
  input wire cause_events_t cause_events,
  input wire logic can_wake_pin,
  input wire logic [6:0] status_low_bits,
  output logic [15:0] mode_control_word,
  output logic [23:0] period_ticks,
  output logic period_known,
  output logic watchdog_off,
  output logic watchdog_enable,
  output logic system_reset_out_n,
  output logic main_rail_enable
);

  // ==================================================================
  // reset release
  logic [1:0] rst_pipe;
  logic rst_n;

  // two flops so release is clean against clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ==================================================================
  // link side: receive on falling edge, send on rising edge
  logic [4:0] rx_count;
  logic [4:0] next_rx_count;
  logic [15:0] rx_shift;
  logic [15:0] next_rx_shift;
  logic [15:0] rx_word;
  logic [15:0] next_rx_word;
  logic frame_toggle;
  logic next_frame_toggle;
  logic [4:0] tx_count;
  logic [4:0] next_tx_count;
  logic next_link_data_out;
  status_word_t status_snap;

  // a full frame latches the word and flips the toggle for the clock side
  always_comb begin
    next_rx_count = rx_count;
    next_rx_shift = {rx_shift[14:0], link_data_in}; // RL14
    next_rx_word = rx_word;
    next_frame_toggle = frame_toggle;
    if (rx_count != 5'h10) begin
      next_rx_count = rx_count + 5'h01;
    end
    if (rx_count == BIT_COUNT_LAST) begin
      next_rx_word = next_rx_shift; // RL14
      next_frame_toggle = ~frame_toggle;
    end
  end

  // counter cleared asynchronously by deselect, so a short frame is dropped
  always_ff @(negedge link_clock or posedge link_select_n) begin
    if (link_select_n) begin
      rx_count <= 5'h00;
    end else begin
      rx_count <= next_rx_count;
    end
  end

  // data holders need no reset; only read after a completed frame
  always_ff @(negedge link_clock) begin
    rx_shift <= next_rx_shift;
    rx_word <= next_rx_word;
  end

  always_ff @(negedge link_clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_toggle <= 1'h0;
    end else begin
      frame_toggle <= next_frame_toggle;
    end
  end

  // snapshot is frozen while selected, so its bits are stable here
  always_comb begin
    next_tx_count = tx_count;
    next_link_data_out = 1'h0;
    if (tx_count != 5'h10) begin
      next_tx_count = tx_count + 5'h01;
      next_link_data_out = status_snap[4'(BIT_COUNT_LAST - tx_count)]; // RL14
    end
  end

  always_ff @(posedge link_clock or posedge link_select_n) begin
    if (link_select_n) begin
      tx_count <= 5'h00;
      link_data_out <= 1'h0;
    end else begin
      tx_count <= next_tx_count;
      link_data_out <= next_link_data_out;
    end
  end

  // ==================================================================
  // crossings into the clock domain: three flops, second and third must agree
  logic [2:0] select_sync;
  logic [2:0] toggle_sync;
  logic [2:0] wake_sync;
  logic select_idle;
  logic next_select_idle;
  logic toggle_seen;
  logic next_toggle_seen;
  logic wake_level;
  logic next_wake_level;
  logic frame_done;
  logic wake_rise;

  always_comb begin
    next_select_idle = select_idle;
    next_toggle_seen = toggle_seen;
    next_wake_level = wake_level;
    frame_done = 1'h0;
    wake_rise = 1'h0;
    if (select_sync[2] == select_sync[1]) begin
      next_select_idle = select_sync[2];
    end
    if (toggle_sync[2] == toggle_sync[1] && toggle_sync[2] != toggle_seen) begin
      next_toggle_seen = toggle_sync[2];
      frame_done = 1'h1;
    end
    if (wake_sync[2] == wake_sync[1] && wake_sync[2] != wake_level) begin
      next_wake_level = wake_sync[2];
      wake_rise = wake_sync[2];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      select_sync <= 3'h7;
      toggle_sync <= 3'h0;
      wake_sync <= 3'h0;
      select_idle <= 1'h1;
      toggle_seen <= 1'h0;
      wake_level <= 1'h0;
    end else begin
      select_sync <= {select_sync[1:0], link_select_n};
      toggle_sync <= {toggle_sync[1:0], frame_toggle};
      wake_sync <= {wake_sync[1:0], can_wake_pin};
      select_idle <= next_select_idle;
      toggle_seen <= next_toggle_seen;
      wake_level <= next_wake_level;
    end
  end

  // ==================================================================
  // status, reset cause and mode control word
  logic [3:0] reset_cause;
  logic [3:0] next_reset_cause;
  logic can_wake_flag;
  logic next_can_wake_flag;
  logic [15:0] next_mode_control_word;
  status_word_t next_status_snap;
  logic status_frame;
  logic any_cause;
  logic [3:0] cause_code;

  // highest code wins when several sources fire together
  always_comb begin
    any_cause = |cause_events;
    cause_code = CAUSE_POWER_ON; // RL7
    if (cause_events.cyclic_wake) cause_code = CAUSE_CYCLIC_WAKE; // RL8
    if (cause_events.main_low) cause_code = CAUSE_MAIN_LOW; // RL7
    if (cause_events.main_overcurrent) cause_code = CAUSE_MAIN_OVERCURRENT; // RL7
    if (cause_events.aux_overload) cause_code = CAUSE_AUX_OVERLOAD; // RL7
    if (cause_events.flash_left) cause_code = CAUSE_FLASH_LEFT; // RL8
    if (cause_events.flash_ready) cause_code = CAUSE_FLASH_READY; // RL8
    if (cause_events.can_wake) cause_code = CAUSE_CAN_WAKE; // RL8
    if (cause_events.local_wake) cause_code = CAUSE_LOCAL_WAKE; // RL8
    if (cause_events.failsafe_wake) cause_code = CAUSE_FAILSAFE_WAKE; // RL8
    if (cause_events.wd_overflow) cause_code = CAUSE_WD_OVERFLOW; // RL9
    if (cause_events.wd_init_missed) cause_code = CAUSE_WD_INIT_MISSED; // RL9
    if (cause_events.wd_early) cause_code = CAUSE_WD_EARLY; // RL9
    if (cause_events.illegal_access) cause_code = CAUSE_ILLEGAL_ACCESS; // RL9
    if (cause_events.int_not_served) cause_code = CAUSE_INT_NOT_SERVED; // RL9
  end

  always_comb begin
    status_frame = frame_done && rx_word[SEL_MSB:SEL_LSB] == SEL_STATUS &&
                   rx_word[READBACK_BIT] == READBACK_STATUS; // RL5
    next_reset_cause = reset_cause;
    next_can_wake_flag = can_wake_flag;
    next_mode_control_word = mode_control_word;
    next_status_snap = status_snap;
    // reading leaves the cause alone; only a new event replaces it
    if (any_cause) begin
      next_reset_cause = cause_code; // RL13
    end
    // set after clear, so a wake in the read cycle is kept
    if (status_frame) begin
      next_can_wake_flag = 1'h0; // RL10
    end
    if (wake_rise) begin
      next_can_wake_flag = 1'h1; // RL10
    end
    if (status_frame && !rx_word[READ_ONLY_BIT]) begin
      next_mode_control_word = rx_word; // RL6
    end
    // refreshed in any mode whenever no frame is under way
    if (select_idle) begin
      next_status_snap.register_select_bits = SEL_STATUS; // RL4
      next_status_snap.readback_select = READBACK_STATUS;
      next_status_snap.read_without_write = 1'h0;
      next_status_snap.reset_cause = reset_cause;
      next_status_snap.can_wake_flag = can_wake_flag;
      next_status_snap.low_bits = status_low_bits;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reset_cause <= CAUSE_RESET;
      can_wake_flag <= CAN_WAKE_RESET;
      mode_control_word <= MODE_WORD_RESET;
      status_snap <= '0;
    end else begin
      reset_cause <= next_reset_cause;
      can_wake_flag <= next_can_wake_flag;
      mode_control_word <= next_mode_control_word;
      status_snap <= next_status_snap;
    end
  end

  // ==================================================================
  // period decode for prescale 11
  logic [15:0] period_ms;
  logic [23:0] next_period_ticks;
  logic next_period_known;
  logic next_watchdog_off;
  logic [5:0] period_code;

  always_comb begin
    period_code = mode_control_word[PERIOD_MSB:PERIOD_LSB];
    period_ms = 16'h0000;
    next_period_known = 1'h0;
    for (int i = 0; i < PERIOD_ENTRIES; i++) begin
      if (period_code == PERIOD_CODE[i] && period_prescale == PRESCALE_TABLE) begin
        next_period_known = 1'h1; // RL1
        unique case (op_mode)
          MODE_NORMAL: period_ms = PERIOD_NORMAL_MS[i];
          MODE_STANDBY: period_ms = PERIOD_STANDBY_MS[i];
          MODE_FLASH: period_ms = PERIOD_FLASH_MS[i];
          MODE_SLEEP: period_ms = PERIOD_SLEEP_MS[i];
        endcase
      end
    end
    next_watchdog_off = period_code == PERIOD_OFF_CODE &&
                        (op_mode == MODE_STANDBY || op_mode == MODE_SLEEP); // RL2
    next_period_ticks = 24'(period_ms) * OSC_TICKS_PER_MS; // RL3
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      period_ticks <= 24'h000000;
      period_known <= 1'h0;
      watchdog_off <= 1'h0;
    end else begin
      period_ticks <= next_period_ticks;
      period_known <= next_period_known;
      watchdog_off <= next_watchdog_off;
    end
  end

  // ==================================================================
  // sleep entry with watchdog off: reset low first, rail off a cycle later
  sleep_state_t sleep_state;
  sleep_state_t next_sleep_state;
  logic next_watchdog_enable;
  logic next_reset_out_n;
  logic next_rail_enable;
  logic sleep_off_req;

  always_comb begin
    sleep_off_req = op_mode == MODE_SLEEP && period_code == PERIOD_OFF_CODE;
    next_sleep_state = sleep_state;
    unique case (sleep_state)
      SLEEP_RUN: if (sleep_off_req) next_sleep_state = SLEEP_RESET_LOW; // RL11
      SLEEP_RESET_LOW: next_sleep_state = SLEEP_RAIL_OFF; // RL12
      SLEEP_RAIL_OFF: if (op_mode != MODE_SLEEP) next_sleep_state = SLEEP_RUN;
      default: next_sleep_state = SLEEP_RUN;
    endcase
    next_reset_out_n = next_sleep_state == SLEEP_RUN; // RL11
    next_watchdog_enable = next_sleep_state == SLEEP_RUN; // RL11
    // rail drops only from the state entered after reset went low
    next_rail_enable = next_sleep_state != SLEEP_RAIL_OFF; // RL12
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleep_state <= SLEEP_RUN;
      system_reset_out_n <= 1'h0;
      watchdog_enable <= 1'h0;
      main_rail_enable <= 1'h1;
    end else begin
      sleep_state <= next_sleep_state;
      system_reset_out_n <= next_reset_out_n;
      watchdog_enable <= next_watchdog_enable;
      main_rail_enable <= next_rail_enable;
    end
  end

endmodule
`default_nettype wire

// *** sbc_status_chk.sv ***
// checker: period decode, sleep entry order and reply framing
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sbc_status_chk
  import sbc_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic link_clock,
  input wire logic link_select_n,
  input wire logic link_data_out,
  input wire op_mode_t op_mode,
  input wire logic [1:0] period_prescale,
  input wire logic [15:0] mode_control_word,
  input wire logic [23:0] period_ticks,
  input wire logic period_known,
  input wire logic watchdog_off,
  input wire logic watchdog_enable,
  input wire logic system_reset_out_n,
  input wire logic main_rail_enable
);
  // ====================
  // helpers
  logic [4:0] rises;
  logic [4:0] next_rises;
  wire [5:0] code = mode_control_word[PERIOD_MSB:PERIOD_LSB];
  wire is_off = code == PERIOD_OFF_CODE;
  wire sleep_off = op_mode == MODE_SLEEP && is_off;
  wire off_cond = (op_mode == MODE_STANDBY || op_mode == MODE_SLEEP) && is_off;
  wire flash_long = op_mode == MODE_FLASH && period_prescale == PRESCALE_TABLE && is_off;
  wire normal_short = op_mode == MODE_NORMAL && period_prescale == PRESCALE_TABLE &&
                      code == PERIOD_CODE[0];
  // rising link edges seen this frame; saturates so stray edges cannot wrap
  always_comb begin
    next_rises = (rises == 5'h10) ? rises : rises + 5'h01;
  end
  always_ff @(posedge link_clock or posedge link_select_n) begin
    if (link_select_n) begin
      rises <= 5'h00;
    end else begin
      rises <= next_rises;
    end
  end
  // ====================
  // assertions
  sequence s_drop;
    !system_reset_out_n && !watchdog_enable ##1 !main_rail_enable;
  endsequence
  chk_sleep_entry: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(sleep_off) |=> s_drop) else $error("sleep entry order wrong");
  chk_rail_after: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(main_rail_enable) |-> !$past(system_reset_out_n)) else $error("rail off too early");
  chk_sleep_exit: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(sleep_off) |=> system_reset_out_n && main_rail_enable) else $error("no sleep exit");
  chk_wd_off: assert property (@(posedge clock) disable iff (!rst_b)
    $stable(off_cond) |-> watchdog_off == off_cond) else $error("watchdog off wrong");
  chk_flash_long: assert property (@(posedge clock) disable iff (!rst_b)
    flash_long && $past(flash_long) |-> period_ticks == 24'he00000 && !watchdog_off)
    else $error("flash long period wrong");
  chk_normal_short: assert property (@(posedge clock) disable iff (!rst_b)
    normal_short && $past(normal_short) |-> period_ticks == 24'h001c00 && period_known)
    else $error("normal short period wrong");
  chk_ticks_scale: assert property (@(posedge clock) disable iff (!rst_b)
    period_known && !watchdog_off |-> period_ticks[8:0] == 9'h000 && period_ticks != 24'h0)
    else $error("ticks not whole ms");
  chk_link_idle: assert property (@(posedge clock) disable iff (!rst_b)
    link_select_n |-> !link_data_out) else $error("data out while idle");
  chk_reply_top: assert property (@(negedge link_clock) disable iff (!rst_b)
    rises != 5'h00 && rises < 5'h05 |-> !link_data_out) else $error("reply top bits set");
endmodule
bind sbc_status_and_watchdog_period sbc_status_chk i_sbc_status_chk (
  .clock(clock), .rst_b(rst_b), .link_clock(link_clock), .link_select_n(link_select_n),
  .link_data_out(link_data_out), .op_mode(op_mode), .period_prescale(period_prescale),
  .mode_control_word(mode_control_word), .period_ticks(period_ticks),
  .period_known(period_known), .watchdog_off(watchdog_off),
  .watchdog_enable(watchdog_enable), .system_reset_out_n(system_reset_out_n),
  .main_rail_enable(main_rail_enable));
`default_nettype wire

// *** sbc_host_model.sv ***
// host model: one 16-bit frame at a time, msb first, full duplex
// assumes the device samples on falling link clock and shifts out on rising
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model (
  output logic link_clock,
  output logic link_select_n,
  output logic link_data_in,
  input wire logic link_data_out,
  output logic [15:0] reply,
  output logic reply_valid
);
  // ====================
  // idle: clock stands low, select high
  initial begin
    link_clock = 1'h0;
    link_select_n = 1'h1;
    link_data_in = 1'h0;
    reply = 16'h0000;
    reply_valid = 1'h0;
  end
  // lead stretches select-to-clock so a slow host is also exercised;
  // the odd 25 ns keeps every link edge off the system clock edges
  task automatic frame(input logic [15:0] tx, input int lead);
    logic [15:0] rx;
    rx = 16'h0000;
    link_select_n = 1'h0;
    #(25 + lead);
    for (int i = 15; i >= 0; i--) begin
      link_clock = 1'h1;
      link_data_in = tx[i];
      #6;
      link_clock = 1'h0;
      rx[i] = link_data_out;
      #6;
    end
    #24;
    link_select_n = 1'h1;
    // released line must not keep showing the last bit
    link_data_in = ~link_data_in;
    reply = rx;
    reply_valid = 1'h1;
    #4;
    reply_valid = 1'h0;
    #44;
  endtask
endmodule
`default_nettype wire

// *** sbc_status_and_watchdog_period_tb.sv ***
// testbench: period table, status replies, wake flag, sleep entry
// assumes the host model makes all frames; other inputs change on falling clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", what, exp, got); end end
module sbc_status_and_watchdog_period_tb
  import sbc_status_pkg::*;
;
  logic clock, rst_b, can_wake_pin, period_known, watchdog_off, watchdog_enable;
  logic system_reset_out_n, main_rail_enable, reply_valid, off;
  wire link_clock, link_select_n, link_data_in, link_data_out;
  op_mode_t op_mode;
  cause_events_t cause_events;
  logic [1:0] period_prescale;
  logic [6:0] status_low_bits;
  logic [3:0] cur;
  logic [15:0] mode_control_word, reply, exp_reply, wr, ms;
  logic [23:0] period_ticks;
  logic [15:0] expq[$];
  int fails, num_checks, seed;
  sbc_status_and_watchdog_period i_sbc_status_and_watchdog_period (.clock(clock),
    .rst_b(rst_b), .link_clock(link_clock), .link_select_n(link_select_n),
    .link_data_in(link_data_in), .link_data_out(link_data_out), .op_mode(op_mode),
    .period_prescale(period_prescale), .cause_events(cause_events),
    .can_wake_pin(can_wake_pin), .status_low_bits(status_low_bits),
    .mode_control_word(mode_control_word), .period_ticks(period_ticks),
    .period_known(period_known), .watchdog_off(watchdog_off),
    .watchdog_enable(watchdog_enable), .system_reset_out_n(system_reset_out_n),
    .main_rail_enable(main_rail_enable));
  sbc_host_model i_sbc_host_model (.link_clock(link_clock), .link_select_n(link_select_n),
    .link_data_in(link_data_in), .link_data_out(link_data_out), .reply(reply),
    .reply_valid(reply_valid));
  // ====================
  // clock and helpers
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  function automatic logic [15:0] rep(input logic [3:0] c, input logic f);
    return {4'h0, c, f, status_low_bits};
  endfunction
  function automatic logic [15:0] ms_of(input int e, input op_mode_t m);
    case (m)
      MODE_NORMAL: return PERIOD_NORMAL_MS[e];
      MODE_STANDBY: return PERIOD_STANDBY_MS[e];
      MODE_FLASH: return PERIOD_FLASH_MS[e];
      default: return PERIOD_SLEEP_MS[e];
    endcase
  endfunction
  // note the expected reply, then let the host send the frame
  task automatic xfer(input logic [15:0] tx, input logic [15:0] exp);
    expq.push_back(exp);
    i_sbc_host_model.frame(tx, seed[0] ? 40 : 0);
    repeat (6) @(negedge clock);
  endtask
  task automatic pulse(input int b);
    @(negedge clock);
    cause_events = 15'h0001 << b;
    @(negedge clock);
    cause_events = '0;
    repeat (4) @(negedge clock);
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ====================
  // reply monitor: oldest note against each finished frame
  always @(posedge reply_valid) begin
    exp_reply = expq.pop_front();
    `CHK("status reply", exp_reply, reply)
  end
  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    #100000;
    fails++;
    $display("[FAIL] run time exp done got timeout");
    wrap_up();
  end
  // ====================
  // tests
  initial begin
    seed = 32'h2e44;
    op_mode = MODE_NORMAL;
    period_prescale = 2'h3;
    cause_events = '0;
    can_wake_pin = 1'h0;
    status_low_bits = 7'($random(seed));
    rst_b = 1'h0;
    repeat (2) @(negedge clock);
    rst_b = 1'h1;
    repeat (12) @(negedge clock);
    `CHK("mode word", MODE_WORD_RESET, mode_control_word)
    `CHK("rail", 1'h1, main_rail_enable)
    xfer(16'h1000, rep(CAUSE_RESET, CAN_WAKE_RESET));
    $display("test reset done");
    for (int e = 0; e < PERIOD_ENTRIES; e++) begin
      wr = {4'h0, PERIOD_CODE[e], 6'($random(seed))};
      xfer(wr, rep(CAUSE_RESET, 1'h0));
      `CHK("mode word", wr, mode_control_word)
      for (int m = 0; m < 4; m++) begin
        op_mode = op_mode_t'(m);
        ms = ms_of(e, op_mode);
        off = ms == 16'h0;
        repeat (3) @(negedge clock);
        `CHK("ticks", 24'(ms) * OSC_TICKS_PER_MS, period_ticks)
        `CHK("known", 1'h1, period_known)
        `CHK("off", off, watchdog_off)
        `CHK("reset out", 1'(!(m == 3 && off)), system_reset_out_n)
        `CHK("wd enable", 1'(!(m == 3 && off)), watchdog_enable)
        `CHK("rail", 1'(!(m == 3 && off)), main_rail_enable)
      end
      op_mode = MODE_NORMAL;
      repeat (2) @(negedge clock);
    end
    period_prescale = 2'($unsigned($random(seed)) % 3);
    repeat (3) @(negedge clock);
    `CHK("known", 1'h0, period_known)
    period_prescale = 2'h3;
    $display("test period table done");
    xfer({4'h1, 6'h12, 6'h3f}, rep(CAUSE_RESET, 1'h0));
    `CHK("mode word", wr, mode_control_word)
    xfer({4'h4, 12'h0ab}, rep(CAUSE_RESET, 1'h0));
    `CHK("mode word", wr, mode_control_word)
    $display("test read only done");
    for (int b = 14; b >= 0; b--) begin
      pulse(b);
      cur = (b <= 6) ? 4'(15 - b) : 4'(14 - b);
      xfer(16'h1000, rep(cur, 1'h0));
    end
    xfer(16'h1000, rep(cur, 1'h0));
    $display("test reset cause done");
    can_wake_pin = 1'h1;
    repeat (10) @(negedge clock);
    can_wake_pin = 1'h0;
    xfer(16'h2000, rep(cur, 1'h1));
    `CHK("mode word", wr, mode_control_word)
    xfer(16'h1000, rep(cur, 1'h1));
    xfer(16'h1000, rep(cur, 1'h0));
    $display("test can wake done");
    wrap_up();
  end
endmodule
`default_nettype wire
